// *** design/ir_remote_defs.vh ***
`ifndef IR_REMOTE_DEFS_VH
`define IR_REMOTE_DEFS_VH

// ********************************
// Clock and time base
// ********************************
`define CLK_MHZ 50
`define TICK_US 10
`define TICK_CYCLES (`CLK_MHZ * `TICK_US)
`define START_MIN_US 1800
`define START_MIN_TICKS ((`START_MIN_US + `TICK_US - 1) / `TICK_US)
`define ONE_MIN_US 900
`define ONE_MIN_TICKS ((`ONE_MIN_US + `TICK_US - 1) / `TICK_US)
`define RELEASE_MS 60
`define RELEASE_TICKS (`RELEASE_MS * 1000 / `TICK_US)
`define FRAME_GAP_MS 10
`define FRAME_GAP_TICKS (`FRAME_GAP_MS * 1000 / `TICK_US)
`define CODE_BITS 12

// ********************************
// Register offsets
// ********************************
`define OFS_CMD 8'h00
`define OFS_CODE 8'h04
`define OFS_STAT 8'h08
`define OFS_IRQ_STAT 8'h0C
`define OFS_IRQ_MASK 8'h10

// ********************************
// Command parameters and defaults
// ********************************
`define CMD_DISABLE 16'h0000
`define CMD_ENABLE 16'h0001
`define CMD_PLAY_LO 16'h000B
`define CMD_PLAY_HI 16'h000E
`define CMD_FREQ_LO 16'h0065
`define CMD_FREQ_HI 16'h0096
`define CMD_FREQ_BASE 16'h0064
`define CMD_DUTY_LO 16'h00E9
`define CMD_DUTY_HI 16'h00FA
`define CMD_DUTY_BASE 16'h00C8
`define CMD_LOAD_LO 16'h03E9
`define CMD_LOAD_HI 16'h0468
`define CMD_STORE_LO 16'h07D1
`define CMD_STORE_HI 16'h0850
`define CARRIER_KHZ_RST 8'h26
`define DUTY_PCT_RST 8'h21
`define PHASE_INC_PER_KHZ 16'h0150
`define DUTY_SCALE 18'h0028F
`define NO_CODE 32'hFFFFFFFF

// ********************************
// Interrupt bits
// ********************************
`define IRQ_KEY 0
`define IRQ_FRAME 1
`define IRQ_DONE 2
`define IRQ_REFUSED 3

`endif

// *** design/ir_remote_learn_playback.v ***
// Summary of operation
// (RULE_01) Command 1 starts IR sampling and decoding; it runs until stopped.
// (RULE_02) Sampling stops at reset, on command 0, or when playback starts.
// (RULE_03) Each decoded remote command is read as one 16-bit code word.
// (RULE_04) Reading the code with no key press returns minus one.
// (RULE_05) A held key gives its code once; later reads give minus one until re-press.
// (RULE_06) Code is device bits above seven command bits; TV keys 1, 2, 0 give 80, 81, 89.
// (RULE_07) Learning keeps every ON and OFF interval length, without decoding.
// (RULE_08) Each received signal overwrites one current buffer while sampling is on.
// (RULE_09) Command 2000 plus n copies the buffer into stored slot n.
// (RULE_10) Command 1000 plus n loads stored slot n back into the buffer.
// (RULE_11) Command 10 plus n plays the buffer on output channel n, one to four.
// (RULE_12) Playback switches the emitter with a 38 kHz, 33 percent carrier.
// (RULE_13) Playback disables sensing; software must enable again before learning.
// (RULE_14) Storage holds 128 slots recallable in any order.
// (RULE_15) Commands 101 to 150 set carrier kHz as value minus 100; default 38.
// (RULE_16) Commands 233 to 250 set duty percent as value minus 200; default 33.
// (RULE_17) ON intervals replay as carrier bursts, OFF intervals as silence.
//
// Our own choices: the Wishbone register port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
`include "ir_remote_defs.vh"

module ir_remote_learn_playback #(
    parameter BUF_DEPTH = 255,
    parameter RELEASE_TICKS = `RELEASE_TICKS,
    parameter FRAME_GAP_TICKS = `FRAME_GAP_TICKS
) (
    input wire clock,
    input wire rst,
    input wire [7:0] wb_adr_i,
    input wire [31:0] wb_dat_i,
    output reg [31:0] wb_dat_o,
    input wire wb_we_i,
    input wire [3:0] wb_sel_i,
    input wire wb_cyc_i,
    input wire wb_stb_i,
    output reg wb_ack_o,
    input wire irSenseN,
    output reg [3:0] pwmOut,
    output wire irq,
    output reg nvReq,
    output reg nvWe,
    output reg [14:0] nvAddr,
    output reg [15:0] nvWrData,
    input wire [15:0] nvRdData,
    input wire nvAck
);

    localparam S_IDLE = 4'b0001;
    localparam S_STORE = 4'b0010;
    localparam S_LOAD = 4'b0100;
    localparam S_PLAY = 4'b1000;
    localparam [8:0] TICK_LAST = `TICK_CYCLES - 1;
    localparam [7:0] BUF_MAX = BUF_DEPTH;
    localparam [15:0] GAP_LIM = FRAME_GAP_TICKS;
    localparam [15:0] ONE_LIM = `ONE_MIN_TICKS;
    localparam [15:0] START_LIM = `START_MIN_TICKS;
    localparam [15:0] REL_LIM = RELEASE_TICKS;
    localparam [3:0] LAST_BIT = `CODE_BITS - 1;

    // ********************************
    // Bus slave
    // ********************************
    reg [3:0] irqStat_r;
    reg [3:0] irqMask_r;
    reg [15:0] code_r;
    reg codeValid_r;
    reg keyHeld_r;
    reg sampleEn_r;
    reg [3:0] state_r;
    reg [7:0] bufLen_r;
    reg [7:0] carrierKhz_r;
    reg [7:0] dutyPct_r;
    reg [15:0] lastCmd_r;
    reg [31:0] rdData;

    wire wbReq = wb_cyc_i & wb_stb_i;
    // Writes and read side effects happen at the edge where ack is seen.
    wire wbWr = wbReq & wb_ack_o & wb_we_i;
    wire wbRd = wbReq & wb_ack_o & ~wb_we_i;
    wire cmdWr = wbWr && (wb_adr_i == `OFS_CMD) && (wb_sel_i[1:0] == 2'b11);
    wire [15:0] cmdVal = wb_dat_i[15:0];
    wire [15:0] playOfs = cmdVal - `CMD_PLAY_LO;
    wire [15:0] freqOfs = cmdVal - `CMD_FREQ_BASE;
    wire [15:0] dutyOfs = cmdVal - `CMD_DUTY_BASE;
    wire [15:0] loadOfs = cmdVal - `CMD_LOAD_LO;
    wire [15:0] storeOfs = cmdVal - `CMD_STORE_LO;
    wire codeRd = wbRd && (wb_adr_i == `OFS_CODE);

    always @* begin
        if (wb_adr_i == `OFS_CMD) begin
            rdData = {16'h0000, lastCmd_r};
        end else if (wb_adr_i == `OFS_CODE) begin
            rdData = codeValid_r ? {16'h0000, code_r} : `NO_CODE; // [RULE_03] [RULE_04]
        end else if (wb_adr_i == `OFS_STAT) begin
            rdData = {dutyPct_r, carrierKhz_r, bufLen_r, 3'b000, keyHeld_r,
                      state_r[3], state_r[1] | state_r[2], 1'b0, sampleEn_r};
        end else if (wb_adr_i == `OFS_IRQ_STAT) begin
            rdData = {28'h0000000, irqStat_r};
        end else if (wb_adr_i == `OFS_IRQ_MASK) begin
            rdData = {28'h0000000, irqMask_r};
        end else begin
            rdData = 32'h00000000;
        end
    end

    always @(posedge clock or posedge rst) begin
        if (rst) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h00000000;
        end else begin
            wb_ack_o <= wbReq & ~wb_ack_o;
            if (wbReq & ~wb_ack_o) begin
                wb_dat_o <= rdData;
            end
        end
    end

    // ********************************
    // Time base
    // ********************************
    reg [8:0] divCnt_r;
    wire tick = (divCnt_r == TICK_LAST);

    always @(posedge clock or posedge rst) begin
        if (rst) begin
            divCnt_r <= 9'h000;
        end else begin
            divCnt_r <= tick ? 9'h000 : divCnt_r + 9'h001;
        end
    end

    // ********************************
    // Receive: interval capture and decoding
    // ********************************
    reg irPrev_r;
    reg inFrame_r;
    reg [15:0] intCnt_r;
    reg [7:0] wrIdx_r;
    reg decActive_r;
    reg [3:0] bitCnt_r;
    reg [11:0] shift_r;
    reg [15:0] relCnt_r;
    reg [15:0] buffer [0:BUF_DEPTH-1];

    wire irOn = ~irSenseN;
    wire irEdge = sampleEn_r & (irOn ^ irPrev_r);
    wire markEnd = irEdge & ~irOn & inFrame_r;
    wire capWr = irEdge & inFrame_r & (wrIdx_r < BUF_MAX);
    wire frameEnd = sampleEn_r & inFrame_r & ~irOn & ~irEdge
                    & (intCnt_r >= GAP_LIM);
    wire markOne = intCnt_r >= ONE_LIM;
    wire [11:0] shiftNxt = {markOne, shift_r[11:1]};
    wire codeDone = markEnd & decActive_r & (bitCnt_r == LAST_BIT);
    wire newKey = codeDone & ~keyHeld_r;

    always @(posedge clock or posedge rst) begin
        if (rst) begin
            irPrev_r <= 1'b0;
            inFrame_r <= 1'b0;
            intCnt_r <= 16'h0000;
            wrIdx_r <= 8'h00;
            decActive_r <= 1'b0;
            bitCnt_r <= 4'h0;
            shift_r <= 12'h000;
        end else begin
            irPrev_r <= irOn;
            if (!sampleEn_r) begin
                inFrame_r <= 1'b0;
                decActive_r <= 1'b0;
            end else if (irEdge) begin
                intCnt_r <= 16'h0000;
                if (!inFrame_r && irOn) begin
                    inFrame_r <= 1'b1;
                    wrIdx_r <= 8'h00; // [RULE_08]
                end else if (capWr) begin
                    wrIdx_r <= wrIdx_r + 8'h01; // [RULE_07]
                end
                if (markEnd) begin
                    if (intCnt_r >= START_LIM) begin
                        decActive_r <= 1'b1;
                        bitCnt_r <= 4'h0;
                        shift_r <= 12'h000;
                    end else if (decActive_r) begin
                        shift_r <= shiftNxt;
                        bitCnt_r <= bitCnt_r + 4'h1;
                        if (codeDone) begin
                            decActive_r <= 1'b0;
                        end
                    end
                end
            end else begin
                if (tick && intCnt_r != 16'hFFFF) begin
                    intCnt_r <= intCnt_r + 16'h0001;
                end
                if (frameEnd) begin
                    inFrame_r <= 1'b0;
                    decActive_r <= 1'b0;
                end
            end
        end
    end

    // Key press tracking; a new key only after the repeats fall silent.
    always @(posedge clock or posedge rst) begin
        if (rst) begin
            code_r <= 16'h0000;
            codeValid_r <= 1'b0;
            keyHeld_r <= 1'b0;
            relCnt_r <= 16'h0000;
        end else begin
            if (codeRd) begin
                codeValid_r <= 1'b0; // [RULE_05]
            end
            if (codeDone) begin
                relCnt_r <= 16'h0000;
                if (!keyHeld_r) begin
                    code_r <= {4'h0, shiftNxt}; // [RULE_06]
                    codeValid_r <= 1'b1;
                    keyHeld_r <= 1'b1;
                end
            end else if (keyHeld_r && tick) begin
                if (relCnt_r >= REL_LIM) begin
                    keyHeld_r <= 1'b0; // [RULE_05]
                end else begin
                    relCnt_r <= relCnt_r + 16'h0001;
                end
            end
        end
    end

    // ********************************
    // Current buffer
    // ********************************
    reg [7:0] nvIdx_r;
    reg [6:0] slot_r;
    wire nvDone = nvReq & nvAck;
    wire ldAck = state_r[2] & nvDone;
    wire ldWr = ldAck & (nvIdx_r != 8'h00);
    wire [7:0] ldLen = (nvRdData[7:0] > BUF_MAX) ? BUF_MAX : nvRdData[7:0];

    // Loading wins over a capture in the same cycle.
    always @(posedge clock) begin
        if (ldWr) begin
            buffer[nvIdx_r - 8'h01] <= nvRdData; // [RULE_10]
        end else if (capWr) begin
            buffer[wrIdx_r] <= intCnt_r; // [RULE_07]
        end
    end

    always @(posedge clock or posedge rst) begin
        if (rst) begin
            bufLen_r <= 8'h00;
        end else if (ldAck && nvIdx_r == 8'h00) begin
            bufLen_r <= ldLen;
        end else if (frameEnd) begin
            bufLen_r <= wrIdx_r; // [RULE_08]
        end
    end

    // ********************************
    // Command sequencer
    // ********************************
    reg [1:0] playCh_r;
    reg [7:0] plIdx_r;
    reg [15:0] plCnt_r;
    reg [23:0] phase_r;
    reg doneEvt_r;
    reg refusedEvt_r;
    wire [7:0] plNext = plIdx_r + 8'h01;

    always @(posedge clock or posedge rst) begin
        if (rst) begin
            state_r <= S_IDLE;
            sampleEn_r <= 1'b0; // [RULE_02]
            carrierKhz_r <= `CARRIER_KHZ_RST; // [RULE_15]
            dutyPct_r <= `DUTY_PCT_RST; // [RULE_16]
            lastCmd_r <= 16'h0000;
            playCh_r <= 2'b00;
            plIdx_r <= 8'h00;
            plCnt_r <= 16'h0000;
            slot_r <= 7'h00;
            nvIdx_r <= 8'h00;
            nvReq <= 1'b0;
            nvWe <= 1'b0;
            nvAddr <= 15'h0000;
            nvWrData <= 16'h0000;
            doneEvt_r <= 1'b0;
            refusedEvt_r <= 1'b0;
        end else begin
            doneEvt_r <= 1'b0;
            refusedEvt_r <= 1'b0;
            if (cmdWr) begin
                lastCmd_r <= cmdVal;
            end
            case (state_r)
                S_IDLE: begin
                    if (cmdWr) begin
                        if (cmdVal == `CMD_DISABLE) begin
                            sampleEn_r <= 1'b0; // [RULE_02]
                        end else if (cmdVal == `CMD_ENABLE) begin
                            sampleEn_r <= 1'b1; // [RULE_01] [RULE_13]
                        end else if (cmdVal >= `CMD_PLAY_LO && cmdVal <= `CMD_PLAY_HI) begin
                            playCh_r <= playOfs[1:0]; // [RULE_11]
                            sampleEn_r <= 1'b0; // [RULE_02] [RULE_13]
                            plIdx_r <= 8'h00;
                            plCnt_r <= buffer[0];
                            state_r <= S_PLAY;
                        end else if (cmdVal >= `CMD_FREQ_LO && cmdVal <= `CMD_FREQ_HI) begin
                            carrierKhz_r <= freqOfs[7:0]; // [RULE_15]
                        end else if (cmdVal >= `CMD_DUTY_LO && cmdVal <= `CMD_DUTY_HI) begin
                            dutyPct_r <= dutyOfs[7:0]; // [RULE_16]
                        end else if (cmdVal >= `CMD_LOAD_LO && cmdVal <= `CMD_LOAD_HI) begin
                            slot_r <= loadOfs[6:0]; // [RULE_10] [RULE_14]
                            nvIdx_r <= 8'h00;
                            state_r <= S_LOAD;
                        end else if (cmdVal >= `CMD_STORE_LO && cmdVal <= `CMD_STORE_HI) begin
                            slot_r <= storeOfs[6:0]; // [RULE_09] [RULE_14]
                            nvIdx_r <= 8'h00;
                            state_r <= S_STORE;
                        end else begin
                            refusedEvt_r <= 1'b1;
                        end
                    end
                end
                S_STORE, S_LOAD: begin
                    // Word 0 of a slot holds the interval count, then the intervals.
                    if (!nvReq) begin
                        nvReq <= 1'b1;
                        nvWe <= state_r[1];
                        nvAddr <= {slot_r, nvIdx_r}; // [RULE_14]
                        nvWrData <= (nvIdx_r == 8'h00) ? {8'h00, bufLen_r}
                                    : buffer[nvIdx_r - 8'h01]; // [RULE_09]
                    end else if (nvAck) begin
                        nvReq <= 1'b0;
                        nvWe <= 1'b0;
                        if ((state_r[1] && nvIdx_r == bufLen_r) ||
                            (state_r[2] && nvIdx_r == 8'h00 && ldLen == 8'h00) ||
                            (state_r[2] && nvIdx_r != 8'h00 && nvIdx_r == bufLen_r)) begin
                            doneEvt_r <= 1'b1;
                            state_r <= S_IDLE;
                        end else begin
                            nvIdx_r <= nvIdx_r + 8'h01;
                        end
                    end
                end
                S_PLAY: begin
                    if (cmdWr) begin
                        refusedEvt_r <= 1'b1;
                    end
                    if (tick) begin
                        if (bufLen_r == 8'h00) begin
                            doneEvt_r <= 1'b1;
                            state_r <= S_IDLE;
                        end else if (plCnt_r != 16'h0000) begin
                            plCnt_r <= plCnt_r - 16'h0001; // [RULE_17]
                        end else if (plNext >= bufLen_r) begin
                            doneEvt_r <= 1'b1;
                            state_r <= S_IDLE;
                        end else begin
                            plIdx_r <= plNext;
                            plCnt_r <= buffer[plNext]; // [RULE_17]
                        end
                    end
                end
                default: begin
                    state_r <= S_IDLE;
                end
            endcase
            if (cmdWr && (state_r[1] || state_r[2])) begin
                refusedEvt_r <= 1'b1;
            end
        end
    end

    // ********************************
    // Carrier and emitter outputs
    // ********************************
    // A phase accumulator avoids a divider; the carrier runs about 0.14 percent fast.
    wire [31:0] phaseProd = carrierKhz_r * `PHASE_INC_PER_KHZ;
    wire [23:0] phaseInc = phaseProd[23:0];
    wire [17:0] dutyProd = {10'h000, dutyPct_r} * `DUTY_SCALE;
    wire carrierHigh = phase_r[23:16] < dutyProd[15:8];
    wire burst = state_r[3] & ~plIdx_r[0] & (bufLen_r != 8'h00);

    always @(posedge clock or posedge rst) begin
        if (rst) begin
            phase_r <= 24'h000000;
            pwmOut <= 4'h0;
        end else begin
            phase_r <= state_r[3] ? phase_r + phaseInc : 24'h000000; // [RULE_12]
            pwmOut <= 4'h0;
            pwmOut[playCh_r] <= burst & carrierHigh; // [RULE_11] [RULE_12] [RULE_17]
        end
    end

    // ********************************
    // Interrupts
    // ********************************
    wire [3:0] irqEvt = {refusedEvt_r, doneEvt_r, frameEnd, newKey};
    wire [3:0] irqClr = (wbWr && wb_adr_i == `OFS_IRQ_STAT && wb_sel_i[0])
                        ? wb_dat_i[3:0] : 4'h0;

    always @(posedge clock or posedge rst) begin
        if (rst) begin
            irqStat_r <= 4'h0;
            irqMask_r <= 4'h0;
        end else begin
            irqStat_r <= (irqStat_r & ~irqClr) | irqEvt;
            if (wbWr && wb_adr_i == `OFS_IRQ_MASK && wb_sel_i[0]) begin
                irqMask_r <= wb_dat_i[3:0];
            end
        end
    end

    assign irq = |(irqStat_r & irqMask_r);

endmodule // ir_remote_learn_playback
`default_nettype wire

// *** tb/ir_remote_monitor.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "ir_remote_defs.vh"

// ********************************
// Port checker
// ********************************
module ir_remote_monitor (
    input wire logic clock,
    input wire logic rst,
    input wire logic [7:0] wb_adr_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_we_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_ack_o,
    input wire logic irSenseN,
    input wire logic [3:0] pwmOut,
    input wire logic irq,
    input wire logic nvReq,
    input wire logic nvWe,
    input wire logic [14:0] nvAddr,
    input wire logic [15:0] nvWrData,
    input wire logic nvAck
);
    logic sawMark_r;
    logic mapped;

    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);

    assign mapped = (wb_adr_i[1:0] == 2'b00) && (wb_adr_i <= 8'h10);

    // A code can only exist once the sensor has seen some carrier.
    always @(posedge clock or posedge rst) begin
        if (rst) begin
            sawMark_r <= 1'b0;
        end else if (!irSenseN) begin
            sawMark_r <= 1'b1;
        end
    end

    a_ack_pulse:
    assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    a_ack_cause:
    assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
        else $error("ack without request");
    a_ack_prompt:
    assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("ack not one cycle after request");
    a_unmapped_zero:
    assert property (wb_ack_o && !wb_we_i && !mapped |-> wb_dat_o == 32'h0)
        else $error("unmapped read not zero");
    a_nv_hold:
    assert property (nvReq && !nvAck |=> nvReq && $stable(nvAddr) && $stable(nvWe)
        && $stable(nvWrData))
        else $error("storage request changed before ack");
    a_pwm_onehot:
    assert property ($onehot0(pwmOut))
        else $error("more than one emitter channel");
    a_pwm_same_ch:
    assert property ((|pwmOut) && $past(|pwmOut) |-> pwmOut == $past(pwmOut))
        else $error("emitter channel changed in a pulse");
    a_code_none:
    assert property (wb_ack_o && !wb_we_i && wb_adr_i == `OFS_CODE && !sawMark_r
        |-> wb_dat_o == `NO_CODE)
        else $error("code read without key not minus one");
    a_reset_quiet:
    assert property ($fell(rst) |-> !wb_ack_o && pwmOut == 4'h0 && !nvReq && !irq)
        else $error("outputs active after reset");
endmodule // ir_remote_monitor

bind ir_remote_learn_playback ir_remote_monitor mon (
    .clock(clock), .rst(rst), .wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o),
    .wb_we_i(wb_we_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o),
    .irSenseN(irSenseN), .pwmOut(pwmOut), .irq(irq), .nvReq(nvReq), .nvWe(nvWe),
    .nvAddr(nvAddr), .nvWrData(nvWrData), .nvAck(nvAck)
);
`default_nettype wire

// *** tb/ir_far_side.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "ir_remote_defs.vh"

// ********************************
// Sensor, emitter and storage model
// ********************************
module ir_far_side (
    input wire logic clock,
    output logic irSenseN,
    input wire logic [3:0] pwmOut,
    input wire logic nvReq,
    input wire logic nvWe,
    input wire logic [14:0] nvAddr,
    input wire logic [15:0] nvWrData,
    output logic [15:0] nvRdData,
    output logic nvAck
);
    logic [15:0] mem [0:32767];
    logic [3:0] chans;
    logic anyPrev = 1'b0;
    int slow = 0;
    int waitCnt = 0;
    int cyc = 0;
    int hiRun = 0;
    int lastRise = 0;
    int minPer, maxHigh, firstRise, lastFall;

    task automatic clr();
        minPer = 1000000;
        maxHigh = 0;
        firstRise = -1;
        lastFall = 0;
        chans = 4'h0;
    endtask

    // Demodulated output idles high and goes low while carrier is seen.
    task automatic pulse(input int onT, input int offT);
        irSenseN <= 1'b0;
        repeat (onT * `TICK_CYCLES) @(posedge clock);
        irSenseN <= 1'b1;
        repeat (offT * `TICK_CYCLES) @(posedge clock);
    endtask

    initial begin
        irSenseN = 1'b1;
        nvAck = 1'b0;
        nvRdData = 16'h0000;
        clr();
    end

    // Read data is inverted each idle cycle so a late sample cannot pass by luck.
    always @(posedge clock) begin
        nvAck <= 1'b0;
        nvRdData <= ~nvRdData;
        if (nvReq && !nvAck) begin
            if (waitCnt >= slow) begin
                waitCnt <= 0;
                nvAck <= 1'b1;
                if (nvWe) mem[nvAddr] <= nvWrData;
                else nvRdData <= mem[nvAddr];
            end else begin
                waitCnt <= waitCnt + 1;
            end
        end
    end

    always @(posedge clock) begin
        cyc <= cyc + 1;
        anyPrev <= |pwmOut;
        chans <= chans | pwmOut;
        if (|pwmOut) hiRun <= hiRun + 1;
        if ((|pwmOut) && !anyPrev) begin
            if (cyc - lastRise < minPer) minPer <= cyc - lastRise;
            if (firstRise < 0) firstRise <= cyc;
            lastRise <= cyc;
            hiRun <= 1;
        end
        if (!(|pwmOut) && anyPrev) begin
            lastFall <= cyc;
            if (hiRun > maxHigh) maxHigh <= hiRun;
        end
    end
endmodule // ir_far_side
`default_nettype wire

// *** tb/ir_remote_learn_playback_tb.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "ir_remote_defs.vh"

// ********************************
// Testbench
// ********************************
module ir_remote_learn_playback_tb;
    logic clock, rst, we, cyc, stb, ack, irSenseN, irq, nvReq, nvWe, nvAck;
    logic [7:0] adr;
    logic [31:0] datW, datR, q;
    logic [3:0] sel, pwmOut;
    logic [14:0] nvAddr;
    logic [15:0] nvWrData, nvRdData;
    int err_total = 0;
    int checks = 0;

    ir_remote_learn_playback #(.BUF_DEPTH(255), .RELEASE_TICKS(40), .FRAME_GAP_TICKS(20)) dut (
        .clock(clock), .rst(rst), .wb_adr_i(adr), .wb_dat_i(datW), .wb_dat_o(datR),
        .wb_we_i(we), .wb_sel_i(sel), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_ack_o(ack),
        .irSenseN(irSenseN), .pwmOut(pwmOut), .irq(irq), .nvReq(nvReq), .nvWe(nvWe),
        .nvAddr(nvAddr), .nvWrData(nvWrData), .nvRdData(nvRdData), .nvAck(nvAck)
    );
    ir_far_side far (
        .clock(clock), .irSenseN(irSenseN), .pwmOut(pwmOut), .nvReq(nvReq), .nvWe(nvWe),
        .nvAddr(nvAddr), .nvWrData(nvWrData), .nvRdData(nvRdData), .nvAck(nvAck)
    );

    initial begin
        clock = 1'b0;
        forever #10 clock = ~clock;
    end

    task automatic test_done();
        if (err_total == 0 && checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            err_total++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic chkIn(input int v, input int lo, input int hi);
        checks++;
        if (v < lo || v > hi) begin
            err_total++;
            $display("[ERR] %0t value %0d outside %0d to %0d", $time, v, lo, hi);
        end
    endtask

    task automatic wbXfer(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clock);
        adr <= a;
        datW <= d;
        we <= w;
        cyc <= 1'b1;
        stb <= 1'b1;
        do begin
            @(posedge clock);
            n++;
        end while (ack !== 1'b1 && n < 50);
        if (ack !== 1'b1) err_total++;
        q = datR;
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        wbXfer(1'b1, a, d);
    endtask

    task automatic rdChk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
        wbXfer(1'b0, a, 32'h0);
        chk(q & m, e);
    endtask

    task automatic irqChk(input logic e);
        @(negedge clock);
        chk({31'h0, irq}, {31'h0, e});
    endtask

    task automatic waitIdle();
        int n;
        n = 0;
        do begin
            wbXfer(1'b0, `OFS_STAT, 32'h0);
            n++;
        end while (q[3:2] !== 2'b00 && n < 4000);
        if (q[3:2] !== 2'b00) err_total++;
    endtask

    // Both plays replay the same loaded buffer: one ON entry of 9, so 10 ticks of carrier.
    task automatic playChk(input logic [3:0] ch, input int pLo, pHi, hLo, hHi);
        chk({28'h0, far.chans}, {28'h0, ch});
        chkIn(far.minPer, pLo, pHi);
        chkIn(far.maxHigh, hLo, hHi);
        chkIn(far.lastFall - far.firstRise, 3600, 5600);
    endtask

    initial begin
        repeat (98000) @(posedge clock);
        err_total++;
        test_done();
    end

    initial begin
        rst = 1'b1;
        adr = 8'h00;
        datW = 32'h0;
        we = 1'b0;
        sel = 4'hF;
        cyc = 1'b0;
        stb = 1'b0;
        repeat (5) @(posedge clock);
        rst <= 1'b0;
        far.mem[15'h0400] = 16'h0002;
        far.mem[15'h0401] = 16'h0009;
        far.mem[15'h0402] = 16'h0004;
        rdChk(`OFS_STAT, 32'hFFFFFFFF, 32'h21260000);
        rdChk(`OFS_CODE, 32'hFFFFFFFF, `NO_CODE);
        rdChk(8'h14, 32'hFFFFFFFF, 32'h0);
        wr(`OFS_CMD, 32'h2);
        rdChk(`OFS_IRQ_STAT, 32'hF, 32'h8);
        irqChk(1'b0);
        wr(`OFS_IRQ_MASK, 32'h8);
        irqChk(1'b1);
        wr(`OFS_IRQ_STAT, 32'h8);
        irqChk(1'b0);
        wr(`OFS_CMD, 32'h1);
        rdChk(`OFS_STAT, 32'h1, 32'h1);
        far.pulse(5, 3);
        far.pulse(7, 25);
        rdChk(`OFS_STAT, 32'hFF00, 32'h0300);
        rdChk(`OFS_IRQ_STAT, 32'h2, 32'h2);
        far.pulse(4, 25);
        rdChk(`OFS_STAT, 32'hFF00, 32'h0100);
        rdChk(`OFS_CODE, 32'hFFFFFFFF, `NO_CODE);
        far.slow = 3;
        wr(`OFS_CMD, 32'd2001);
        waitIdle();
        chk({16'h0, far.mem[0]}, 32'h1);
        chkIn(far.mem[1], 3, 5);
        wr(`OFS_CMD, 32'h0);
        rdChk(`OFS_STAT, 32'h5, 32'h0);
        wr(`OFS_CMD, 32'd1005);
        waitIdle();
        rdChk(`OFS_STAT, 32'hFF00, 32'h0200);
        wr(`OFS_CMD, 32'h1);
        far.clr();
        wr(`OFS_CMD, 32'd11);
        rdChk(`OFS_STAT, 32'h9, 32'h8);
        waitIdle();
        playChk(4'h1, 1300, 1330, 420, 450);
        wr(`OFS_CMD, 32'd140);
        wr(`OFS_CMD, 32'd250);
        rdChk(`OFS_STAT, 32'hFFFF0000, 32'h32280000);
        far.clr();
        wr(`OFS_CMD, 32'd14);
        waitIdle();
        playChk(4'h8, 1235, 1265, 605, 645);
        far.pulse(6, 25);
        rdChk(`OFS_STAT, 32'hFF01, 32'h0200);
        test_done();
    end
endmodule // ir_remote_learn_playback_tb
`default_nettype wire
